/* File: src/pam_cycle_watch.sv */
// Purpose: Counts-not-achieved watchdog on the pump cycle switch.
// Assumes: cyc_pulse is one cycle per detected stroke.
// Notes: Armed only while the pump runs in any mode but time mode.
`timescale 1ns/1ps
`default_nettype none
module pam_cycle_watch (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic armed,
    input wire logic cyc_pulse,
    input wire logic [31:0] timeout,
    // Result
    output logic expired
);
    logic [31:0] cnt_r;

    always_ff @(posedge mclk) begin
        if (rst || !armed || cyc_pulse) begin
            cnt_r <= 32'h00000000;
        end else if (cnt_r != timeout) begin
            cnt_r <= cnt_r + 32'h00000001;
        end
    end
    assign expired = armed && !cyc_pulse && (cnt_r == timeout); // RULE_10

    a_watch_reset_pulse: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        cyc_pulse && timeout > 32'h1 |=> !expired)
        else $error("expiry right after a pulse");
endmodule // pam_cycle_watch
`default_nettype wire

/* File: src/pam_map.svh */
// Purpose: Register offsets, reset values and timing counts of the pump alarm monitor.
// Assumes: AHB-Lite slave, 32-bit words, 100 MHz mclk.
// Notes: Definitions only.
`ifndef PAM_MAP_SVH
`define PAM_MAP_SVH
// =====================================================================
// Register offsets (byte addresses)
`define PAM_OFF_CTRL 12'h000
`define PAM_OFF_CAL 12'h004
`define PAM_OFF_THR 12'h008
`define PAM_OFF_TMO 12'h00C
`define PAM_OFF_STAT 12'h010
`define PAM_OFF_PRESS 12'h014
`define PAM_OFF_RUN 12'h018
`define PAM_OFF_CMD 12'h01C
// =====================================================================
// Control register fields and register reset values
`define PAM_CTRL_IN1_NC 0
`define PAM_CTRL_IN2_NC 1
`define PAM_CTRL_RDIS_NC 2
`define PAM_CTRL_PSAVE 3
`define PAM_CTRL_MODE_LO 4
`define PAM_CTRL_RST 32'h00000000
`define PAM_CAL_RST 32'h00000000
`define PAM_THR_RST 32'hFFFF0000
`define PAM_TMO_RST 32'h05F5E100
// =====================================================================
// Command register bits
`define PAM_CMD_WEB 0
`define PAM_CMD_SCADA 1
// =====================================================================
// Timing
`define PAM_CLK_MHZ 100
`define PAM_MS_CYC (1000 * `PAM_CLK_MHZ)
`endif

/* File: src/pam_monitor.sv */
// Purpose: Alarm and signal-event supervisor for a chemical injection pump controller.
// Assumes: AHB-Lite single word transfers; switch inputs synchronous to mclk.
// Notes: Zero wait-state slave; OKAY response only.
// Behaviour
// RULE_01: Any active alarm or signal event forces pump standby.
// RULE_02: An active condition posts a status code and lights the function LED.
// RULE_03: Local reset key clears latched alarms.
// RULE_04: Web reset request clears latched alarms like the key.
// RULE_05: SCADA reset command clears latched alarms like the key.
// RULE_06: Each switch input latches its own alarm, polarity set per input.
// RULE_07: Remote-disable input gives a self-clearing standby event, polarity configurable.
// RULE_08: Pressure above upper threshold latches a high-pressure alarm.
// RULE_09: Pressure below lower threshold latches a low-pressure alarm.
// RULE_10: Missing cycle-switch pulse within timeout latches counts-not-achieved.
// RULE_11: Pressure uses calibration offset and sensitivity from the transducer label.
// RULE_12: Pressure reads zero when no transducer is connected.
// RULE_13: Supply voltage is hidden from run status when power save is off.
// RULE_14: Run status shows metering mode and pump on or off phase.
// RULE_15: Standby ends only when no alarm and no event remain.
`include "pam_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pam_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Field inputs
    input wire logic sw_in1,
    input wire logic sw_in2,
    input wire logic remote_dis,
    input wire logic reset_key,
    input wire logic cyc_switch,
    input wire logic [15:0] press_raw,
    input wire logic press_present,
    input wire logic [15:0] supply_mv,
    input wire logic pump_on_phase,
    // Pump and indicator outputs
    output logic pump_standby,
    output logic func_led,
    output logic [7:0] status_code,
    output logic [31:0] run_status
);
    // =================================================================
    // Bus slave
    logic ph_wr_r;
    logic ph_rd_r;
    logic [11:0] ph_addr_r;
    logic [31:0] ctrl_r;
    logic [31:0] cal_r;
    logic [31:0] thr_r;
    logic [31:0] tmo_r;
    logic web_rst;
    logic scada_rst;
    logic addr_ok;
    logic [31:0] rd_nxt;
    pam_pkg::pam_alarm_t alarm_r;
    pam_pkg::pam_alarm_t alarm_set;
    pam_pkg::pam_cal_t cal;
    pam_pkg::pam_mode_t mode;
    logic [15:0] press;
    logic press_ok_r;
    logic press_valid;
    logic cyc_sync_r;
    logic cyc_prev_r;
    logic cyc_pulse;
    logic expired;
    logic in1_act;
    logic in2_act;
    logic event_act;
    logic any_alarm;
    logic clear_req;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ph_wr_r <= 1'b0;
            ph_rd_r <= 1'b0;
            ph_addr_r <= 12'h000;
        end else if (hready) begin
            ph_wr_r <= hsel && htrans[1] && hwrite;
            ph_rd_r <= hsel && htrans[1] && !hwrite;
            ph_addr_r <= haddr;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= `PAM_CTRL_RST;
            cal_r <= `PAM_CAL_RST;
            thr_r <= `PAM_THR_RST;
            tmo_r <= `PAM_TMO_RST;
        end else if (ph_wr_r) begin
            unique case (ph_addr_r)
                `PAM_OFF_CTRL: begin
                    ctrl_r <= {26'h0000000, hwdata[5:0]};
                end
                `PAM_OFF_CAL: begin
                    cal_r <= hwdata; // RULE_11
                end
                `PAM_OFF_THR: begin
                    thr_r <= hwdata;
                end
                `PAM_OFF_TMO: begin
                    tmo_r <= hwdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Command writes are pulses; nothing is stored.
    assign web_rst = ph_wr_r && ph_addr_r == `PAM_OFF_CMD && hwdata[`PAM_CMD_WEB]; // RULE_04
    assign scada_rst = ph_wr_r && ph_addr_r == `PAM_OFF_CMD && hwdata[`PAM_CMD_SCADA]; // RULE_05

    always_comb begin
        addr_ok = 1'b1;
        unique case (haddr)
            `PAM_OFF_CTRL: rd_nxt = ctrl_r;
            `PAM_OFF_CAL: rd_nxt = cal_r;
            `PAM_OFF_THR: rd_nxt = thr_r;
            `PAM_OFF_TMO: rd_nxt = tmo_r;
            `PAM_OFF_STAT: rd_nxt = {22'h000000, event_act, 1'b0, status_code};
            `PAM_OFF_PRESS: rd_nxt = {16'h0000, press};
            `PAM_OFF_RUN: rd_nxt = run_status;
            default: begin
                rd_nxt = 32'h00000000;
                addr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= addr_ok ? rd_nxt : 32'h00000000;
        end
    end

    // =================================================================
    // Pressure and cycle watchdog
    assign cal = pam_pkg::pam_cal_t'(cal_r);
    assign mode = pam_pkg::pam_mode_t'(ctrl_r[`PAM_CTRL_MODE_LO +: 2]);

    pam_press_conv u_conv (
        .mclk(mclk),
        .rst(rst),
        .raw(press_raw),
        .present(press_present),
        .cal(cal),
        .press(press)
    );

    // The converted value trails the attach flag by one edge.
    // Judging it any earlier would see the stale zero and raise a false low-pressure alarm on every reconnect.
    // Removal is seen at once, so a reset pressed while unplugging clears the pressure alarms.
    always_ff @(posedge mclk) begin
        if (rst) begin
            press_ok_r <= 1'b0;
        end else begin
            press_ok_r <= press_present;
        end
    end
    assign press_valid = press_present && press_ok_r; // RULE_12

    always_ff @(posedge mclk) begin
        if (rst) begin
            cyc_sync_r <= 1'b0;
            cyc_prev_r <= 1'b0;
        end else begin
            cyc_sync_r <= cyc_switch;
            cyc_prev_r <= cyc_sync_r;
        end
    end
    assign cyc_pulse = cyc_sync_r && !cyc_prev_r;

    pam_cycle_watch u_watch (
        .mclk(mclk),
        .rst(rst),
        .armed((mode != pam_pkg::PAM_MODE_TIME) && pump_on_phase && !pump_standby),
        .cyc_pulse(cyc_pulse),
        .timeout(tmo_r),
        .expired(expired)
    );

    // =================================================================
    // Alarm latches
    // Polarity: a normally-closed input is active when it opens (low).
    assign in1_act = sw_in1 ^ ctrl_r[`PAM_CTRL_IN1_NC]; // RULE_06
    assign in2_act = sw_in2 ^ ctrl_r[`PAM_CTRL_IN2_NC]; // RULE_06
    assign event_act = remote_dis ^ ctrl_r[`PAM_CTRL_RDIS_NC]; // RULE_07

    always_comb begin
        alarm_set.in1 = in1_act; // RULE_06
        alarm_set.in2 = in2_act; // RULE_06
        alarm_set.high_press = press_valid && press > thr_r[31:16]; // RULE_08
        alarm_set.low_press = press_valid && press < thr_r[15:0]; // RULE_09
        alarm_set.counts = expired; // RULE_10
    end

    assign clear_req = reset_key || web_rst || scada_rst; // RULE_03

    // A condition still present at reset re-latches: set wins over clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            alarm_r <= '0;
        end else if (clear_req) begin
            alarm_r <= alarm_set; // RULE_03 RULE_04 RULE_05
        end else begin
            alarm_r <= alarm_r | alarm_set;
        end
    end
    assign any_alarm = |alarm_r;

    // =================================================================
    // Outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            pump_standby <= 1'b0;
            func_led <= 1'b0;
            status_code <= 8'h00;
        end else begin
            pump_standby <= any_alarm || event_act; // RULE_01 RULE_15
            func_led <= any_alarm || event_act; // RULE_02
            status_code <= {2'h0, event_act, alarm_r}; // RULE_02
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            run_status <= 32'h00000000;
        end else begin
            run_status <= {ctrl_r[`PAM_CTRL_PSAVE] ? supply_mv : 16'h0000, // RULE_13
                13'h0000, pump_on_phase && !pump_standby, mode}; // RULE_14
        end
    end

    // =================================================================
    // Output checks
    a_standby_follows: assert property (@(posedge mclk) disable iff (rst) // RULE_01
        (any_alarm || event_act) |=> pump_standby)
        else $error("standby missing");
    a_led_status: assert property (@(posedge mclk) disable iff (rst) // RULE_02
        event_act |=> func_led && status_code[5])
        else $error("event not posted");
    a_led_alarm: assert property (@(posedge mclk) disable iff (rst) // RULE_02
        any_alarm |=> func_led)
        else $error("alarm did not light the indicator");
    a_led_dark: assert property (@(posedge mclk) disable iff (rst) // RULE_02
        !any_alarm && !event_act |=> !func_led)
        else $error("indicator lit with nothing active");
    a_status_code: assert property (@(posedge mclk) disable iff (rst) // RULE_02
        1'b1 |=> status_code == {2'h0, $past(event_act), $past(alarm_r)})
        else $error("status code does not name the active conditions");

    // =================================================================
    // Alarm latch checks
    a_key_clears: assert property (@(posedge mclk) disable iff (rst) // RULE_03
        reset_key && alarm_set == '0 |=> alarm_r == '0)
        else $error("key did not clear");
    a_web_clears: assert property (@(posedge mclk) disable iff (rst) // RULE_04
        web_rst && alarm_set == '0 |=> alarm_r == '0)
        else $error("web reset failed");
    a_scada_clears: assert property (@(posedge mclk) disable iff (rst) // RULE_05
        scada_rst && alarm_set == '0 |=> alarm_r == '0)
        else $error("scada reset failed");
    // A clear loads what is present now, so a condition that persists through it stays set.
    a_clear_loads: assert property (@(posedge mclk) disable iff (rst) // RULE_03
        clear_req |=> alarm_r == $past(alarm_set))
        else $error("clear did not load the present conditions");
    // Without a clear the latch may only gain bits, never lose them.
    a_alarm_hold: assert property (@(posedge mclk) disable iff (rst) // RULE_06
        !clear_req |=> (alarm_r | $past(alarm_r)) == alarm_r)
        else $error("alarm dropped without a reset");
    a_in1_latch: assert property (@(posedge mclk) disable iff (rst) // RULE_06
        in1_act ##1 !clear_req [*2] |=> alarm_r.in1)
        else $error("input 1 alarm lost");
    a_in2_latch: assert property (@(posedge mclk) disable iff (rst) // RULE_06
        in2_act ##1 !clear_req [*2] |=> alarm_r.in2)
        else $error("input 2 alarm lost");
    a_event_self: assert property (@(posedge mclk) disable iff (rst) // RULE_07
        !event_act && !any_alarm |=> !pump_standby)
        else $error("event did not self clear");
    a_high_press: assert property (@(posedge mclk) disable iff (rst) // RULE_08
        press_valid && press > thr_r[31:16] |=> alarm_r.high_press)
        else $error("high pressure missed");
    a_low_press: assert property (@(posedge mclk) disable iff (rst) // RULE_09
        press_valid && press < thr_r[15:0] |=> alarm_r.low_press)
        else $error("low pressure missed");
    a_counts_latch: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        expired |=> alarm_r.counts)
        else $error("counts alarm missed");
    a_time_no_watch: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        mode == pam_pkg::PAM_MODE_TIME |-> !expired)
        else $error("watchdog expired in time mode");
    a_no_early_run: assert property (@(posedge mclk) disable iff (rst) // RULE_15
        clear_req && event_act |=> pump_standby)
        else $error("reset released standby");

    // =================================================================
    // Run status and bus checks
    a_volt_hidden: assert property (@(posedge mclk) disable iff (rst) // RULE_13
        !ctrl_r[`PAM_CTRL_PSAVE] |=> run_status[31:16] == 16'h0000)
        else $error("voltage shown");
    a_volt_shown: assert property (@(posedge mclk) disable iff (rst) // RULE_13
        ctrl_r[`PAM_CTRL_PSAVE] |=> run_status[31:16] == $past(supply_mv))
        else $error("voltage not shown in power save");
    a_mode_shown: assert property (@(posedge mclk) disable iff (rst) // RULE_14
        1'b1 |=> run_status[1:0] == $past(ctrl_r[5:4]))
        else $error("mode not reported");
    a_phase_shown: assert property (@(posedge mclk) disable iff (rst) // RULE_14
        1'b1 |=> run_status[2] == $past(pump_on_phase && !pump_standby))
        else $error("pump phase not reported");
    // Zero wait states: read data is the register as it stood at the address edge.
    a_read_ctrl: assert property (@(posedge mclk) disable iff (rst)
        hready && hsel && htrans[1] && !hwrite && haddr == `PAM_OFF_CTRL |=> hrdata == $past(ctrl_r))
        else $error("control read data wrong");
    a_write_ctrl: assert property (@(posedge mclk) disable iff (rst)
        ph_wr_r && ph_addr_r == `PAM_OFF_CTRL |=> ctrl_r == {26'h0, $past(hwdata[5:0])})
        else $error("control write did not land");
    a_thr_write: assert property (@(posedge mclk) disable iff (rst)
        ph_wr_r && ph_addr_r == `PAM_OFF_THR |=> thr_r == $past(hwdata))
        else $error("threshold write did not land");
endmodule // pam_monitor
`default_nettype wire

/* File: src/pam_pkg.sv */
// Purpose: Types shared by the pump alarm monitor files.
// Assumes: Constants come from pam_map.svh.
// Notes: No import; use pam_pkg::name.
package pam_pkg;
    // =================================================================
    // Types
    typedef enum logic [1:0] {
        PAM_MODE_FLOW = 2'h0,
        PAM_MODE_TIME = 2'h1,
        PAM_MODE_CYCLE = 2'h2
    } pam_mode_t;

    typedef struct packed {
        logic in1;
        logic in2;
        logic high_press;
        logic low_press;
        logic counts;
    } pam_alarm_t;

    typedef struct packed {
        logic [15:0] offset;
        logic [15:0] sens;
    } pam_cal_t;
endpackage

/* File: src/pam_press_conv.sv */
// Purpose: Converts a raw transducer sample to pressure.
// Assumes: Pressure = (raw - offset) * sens / 256, saturated to 16 bits.
// Notes: Reports zero with no transducer attached.
`timescale 1ns/1ps
`default_nettype none
module pam_press_conv (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Sample and calibration
    input wire logic [15:0] raw,
    input wire logic present,
    input wire pam_pkg::pam_cal_t cal,
    // Result
    output logic [15:0] press
);
    logic [15:0] diff;
    logic [31:0] prod;
    logic [23:0] scaled;
    // The offset clamps at zero so a low reading never wraps to full scale.
    assign diff = (raw > cal.offset) ? raw - cal.offset : 16'h0000; // RULE_11
    assign prod = diff * cal.sens; // RULE_11
    assign scaled = prod[31:8];

    always_ff @(posedge mclk) begin
        if (rst) begin
            press <= 16'h0000;
        end else if (!present) begin
            press <= 16'h0000; // RULE_12
        end else begin
            press <= (scaled[23:16] != 8'h00) ? 16'hFFFF : scaled[15:0];
        end
    end

    a_press_zero_absent: assert property (@(posedge mclk) disable iff (rst) // RULE_12
        !present |=> press == 16'h0000)
        else $error("pressure not zero without transducer");
endmodule // pam_press_conv
`default_nettype wire

/* File: testbench/pam_field_model.sv */
// Purpose: Behavioural pump motor and cycle switch at the far side of the alarm monitor.
// Assumes: One stroke pulse every STROKE_CYC cycles while strokes are enabled and the pump runs.
// Notes: The switch rests low between strokes.
`timescale 1ns/1ps
`default_nettype none
module pam_field_model #(
    parameter int STROKE_CYC = 8
) (
    // Clock
    input wire logic mclk,
    // Pump state
    input wire logic stroke_en,
    input wire logic pump_standby,
    // Cycle switch
    output logic cyc_switch
);
    int cnt = 0;
    logic stroke_r = 1'h0;
    assign cyc_switch = stroke_r;
    // A pump in standby makes no strokes, so the watchdog sees the real motor state.
    always @(posedge mclk) begin
        if (!stroke_en || pump_standby) begin
            cnt <= 0;
            stroke_r <= 1'h0;
        end else begin
            cnt <= (cnt == STROKE_CYC - 1) ? 0 : cnt + 1;
            stroke_r <= (cnt == 0);
        end
    end
endmodule // pam_field_model
`default_nettype wire

/* File: testbench/pam_monitor_test.sv */
// Purpose: Self-checking bench for the pump alarm monitor.
// Assumes: Zero wait-state slave; every task returns at a rising edge.
// Notes: Outputs are sampled at an edge, before that edge's updates land.
`include "pam_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pam_monitor_test;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic hsel = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic sw_in1 = 1'h0;
    logic sw_in2 = 1'h0;
    logic remote_dis = 1'h0;
    logic reset_key = 1'h0;
    logic [15:0] press_raw = 16'h0;
    logic press_present = 1'h0;
    logic [15:0] supply_mv = 16'h0;
    logic pump_on_phase = 1'h0;
    logic stroke_en = 1'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic cyc_switch;
    wire logic pump_standby;
    wire logic func_led;
    wire logic [7:0] status_code;
    wire logic [31:0] run_status;
    int num_errors = 0;
    int tests_run = 0;

    pam_monitor uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sw_in1(sw_in1), .sw_in2(sw_in2),
        .remote_dis(remote_dis), .reset_key(reset_key), .cyc_switch(cyc_switch),
        .press_raw(press_raw), .press_present(press_present), .supply_mv(supply_mv),
        .pump_on_phase(pump_on_phase), .pump_standby(pump_standby), .func_led(func_led),
        .status_code(status_code), .run_status(run_status));
    pam_field_model field (.mclk(mclk), .stroke_en(stroke_en), .pump_standby(pump_standby),
        .cyc_switch(cyc_switch));

    initial begin
        forever #5 mclk = ~mclk;
    end
    // =====================================================================
    // Common tasks
    task automatic close_out;
        $display("compared %0d, mismatched %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // Waits for hready at a rising edge; the bound stands in for a hung slave.
    task automatic bus_wait;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'h1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 50) begin
            num_errors++;
            $display("ERROR %0t bus wait ran out", $time);
            close_out();
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        bus_wait();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        bus_wait();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        xfer(1'h1, a, d, rd);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        xfer(1'h0, a, 32'h0, rd);
        chk_word(rd, exp);
    endtask
    task automatic key_press;
        reset_key <= 1'h1;
        step(1);
        reset_key <= 1'h0;
        step(5);
    endtask
    // =====================================================================
    // Scenarios
    task automatic t_reset;
        rdchk(`PAM_OFF_CTRL, `PAM_CTRL_RST);
        rdchk(`PAM_OFF_CAL, `PAM_CAL_RST);
        rdchk(`PAM_OFF_THR, `PAM_THR_RST);
        rdchk(`PAM_OFF_TMO, `PAM_TMO_RST);
        rdchk(12'h020, 32'h0);
        chk_bit(hresp, 1'h0);
        chk_bit(pump_standby, 1'h0);
        $display("test reset done");
    endtask
    task automatic t_switch;
        sw_in1 <= 1'h1;
        step(1);
        sw_in1 <= 1'h0;
        step(5);
        chk_word({24'h0, status_code}, 32'h10);
        chk_bit(pump_standby, 1'h1);
        chk_bit(func_led, 1'h1);
        key_press();
        chk_word({24'h0, status_code}, 32'h0);
        chk_bit(pump_standby, 1'h0);
        wr(`PAM_OFF_CTRL, 32'h2);
        step(5);
        chk_word({24'h0, status_code}, 32'h08);
        sw_in2 <= 1'h1;
        wr(`PAM_OFF_CMD, 32'h1);
        step(5);
        chk_word({24'h0, status_code}, 32'h0);
        chk_bit(func_led, 1'h0);
        $display("test switch done");
    endtask
    task automatic t_remote;
        remote_dis <= 1'h1;
        step(5);
        chk_bit(pump_standby, 1'h1);
        rdchk(`PAM_OFF_STAT, 32'h220);
        key_press();
        chk_bit(pump_standby, 1'h1);
        remote_dis <= 1'h0;
        step(4);
        chk_bit(pump_standby, 1'h0);
        $display("test remote done");
    endtask
    task automatic t_press;
        wr(`PAM_OFF_CAL, 32'h00100200);
        wr(`PAM_OFF_THR, 32'h03000100);
        press_present <= 1'h1;
        press_raw <= 16'h0110;
        step(5);
        rdchk(`PAM_OFF_PRESS, 32'h200);
        chk_word({24'h0, status_code}, 32'h0);
        press_raw <= 16'h0210;
        step(5);
        chk_word({24'h0, status_code}, 32'h04);
        press_raw <= 16'h0110;
        wr(`PAM_OFF_CMD, 32'h2);
        step(5);
        chk_word({24'h0, status_code}, 32'h0);
        press_raw <= 16'h0005;
        step(5);
        rdchk(`PAM_OFF_PRESS, 32'h0);
        chk_word({24'h0, status_code}, 32'h02);
        press_present <= 1'h0;
        press_raw <= 16'h0210;
        key_press();
        rdchk(`PAM_OFF_PRESS, 32'h0);
        chk_word({24'h0, status_code}, 32'h0);
        $display("test pressure done");
    endtask
    task automatic t_counts;
        wr(`PAM_OFF_TMO, 32'h14);
        pump_on_phase <= 1'h1;
        step(10);
        chk_word({24'h0, status_code}, 32'h0);
        step(30);
        chk_word({24'h0, status_code}, 32'h01);
        pump_on_phase <= 1'h0;
        key_press();
        stroke_en <= 1'h1;
        pump_on_phase <= 1'h1;
        step(80);
        chk_word({24'h0, status_code}, 32'h0);
        $display("test counts done");
    endtask
    task automatic t_run;
        logic [31:0] exp;
        supply_mv <= 16'h1234;
        for (int m = 0; m < 3; m++) begin
            for (int p = 0; p < 2; p++) begin
                wr(`PAM_OFF_CTRL, 32'h2 | 32'(m << 4) | 32'(p << 3));
                step(3);
                exp = {(p == 1) ? 16'h1234 : 16'h0000, 13'h0, 1'h1, m[1:0]};
                chk_word(run_status, exp);
                rdchk(`PAM_OFF_RUN, exp);
            end
        end
        pump_on_phase <= 1'h0;
        step(3);
        chk_bit(run_status[2], 1'h0);
        $display("test run status done");
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        step(16);
        rst <= 1'h0;
        step(1);
        t_reset();
        t_switch();
        t_remote();
        t_press();
        t_counts();
        t_run();
        close_out();
    end
endmodule // pam_monitor_test
`default_nettype wire
